// >>> hw/dmc_pkg.sv
package dmc_pkg;

  // Command codes seen on either port
  localparam logic [7:0] CMD_OWN_STATUS   = 8'hD7;
  localparam logic [7:0] CMD_TAKE_OVER    = 8'hD8;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;

  // Ownership status byte layout, one nibble per port
  localparam int         PORT_NIBBLE      = 4;
  localparam int         BIT_CMD_ERR      = 3;
  localparam int         BIT_ALERT_EN     = 2;
  localparam int         BIT_REQUESTED    = 1;
  localparam int         BIT_HOLDS        = 0;
  localparam logic [7:0] OWN_STATUS_RESET = 8'h01;

  // Width of the live supply status vector (standard and maker-specific)
  localparam int         STAT_W           = 16;
  localparam logic [15:0] STAT_ZERO       = 16'h0000;

  // Per-port decoded transaction from the serial front end
  typedef struct packed {
    logic       valid;    // One-cycle pulse: command complete
    logic       rd;       // Read transaction
    logic [7:0] code;     // Command code
    logic       pec_ok;   // Trailing PEC checked good
    logic       wr_open;  // Control transaction open, drops at STOP
  } dmc_req_t;

  // Per-port answer to the serial front end
  typedef struct packed {
    logic       rd_valid;   // Local read data ready
    logic [7:0] rd_data;
    logic       exec;       // Pass command to the supply core
    logic       exec_rd;
    logic [7:0] exec_code;
    logic       stretch;    // Hold the clock low
  } dmc_rsp_t;

  typedef enum logic {
    XF_IDLE = 1'b0,
    XF_WAIT = 1'b1
  } dmc_xfer_t;

endpackage

// >>> hw/dmc_arbiter.sv
// How it works
// - Two independent ports, each with its own decode and Alert# output.
// - Either host may claim authority when idle; a dead host cannot block.
// - Ownership status byte at 0xD7 readable from either port any time.
// - Clock is stretched on any transaction while the core is busy.
// - Port 1 flags in bits 7..4, port 0 in 3..0; only bit 0 resets high.
// - Ownership status returns to default on bias (power-on) reset.
// - Non-owner may only execute take-over and clear-faults writes.
// - Take-over at 0xD8 moves authority to the port it arrived on.
// - Transfer waits until the owner's control transaction ends with STOP.
// - An owner busy only reading does not delay the transfer.
// - Reads on both ports are served in the same cycle.
// - Take-over acts only after its PEC byte has checked good.
// - After a transfer both Alert# lines assert.
// - Supply fault registers clear only on clear-faults from the owner.
// - Status latches only in a final state, raising Alert# until cleared.
// - Further changes are OR-ed into the latched set, never removed.
// - External faults raise no fault indicator, pin or alarm.
// - Power-up raises a notification, cleared by the owner's status read or clear-faults.
// - Any change in the status bits outside ext_mask raises Alert# in a final state.
// - Each Alert# combines the supply alert and that port's selector alert.
`timescale 1ns/1ps

module dmc_arbiter (
  // System
  input  wire logic                           clk_sys,
  input  wire logic                           reset,
  // Serial front ends, index is port number
  input  wire dmc_pkg::dmc_req_t [1:0]        port_req,
  output dmc_pkg::dmc_rsp_t [1:0]             port_rsp,
  // Alert# pins, open drain
  output logic [1:0]                          alert_out,
  output logic [1:0]                          alert_oe_n,
  // Supply core
  input  wire logic                           core_busy,
  input  wire logic [dmc_pkg::STAT_W-1:0]     status_live,
  input  wire logic [dmc_pkg::STAT_W-1:0]     ext_mask,
  input  wire logic                           final_state,
  output logic                                fault_clear,
  output logic                                alarm,
  output logic [dmc_pkg::STAT_W-1:0]          notif,
  output logic                                owner
);

  dmc_pkg::dmc_xfer_t        xfer_state;
  dmc_pkg::dmc_xfer_t        next_xfer_state;
  logic [1:0]                req_flag;
  logic [1:0]                err_flag;
  logic [1:0]                sel_alert;
  logic [1:0]                take_ok;
  logic [1:0]                clr_cmd;
  logic [1:0]                bad_cmd;
  logic [1:0]                fwd_cmd;
  logic [1:0]                own_stat_rd;
  logic [7:0]                own_status;
  logic [dmc_pkg::STAT_W-1:0] stat_ref;
  logic [dmc_pkg::STAT_W-1:0] stat_change;
  logic                      pwr_note;
  logic                      xfer_go;
  logic                      owner_clr;
  logic                      fault_alert;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Holds-control flags come from one register, so they can never both be set
  always_comb begin
    own_status = '0;
    own_status[dmc_pkg::BIT_HOLDS]                            = ~owner;
    own_status[dmc_pkg::PORT_NIBBLE + dmc_pkg::BIT_HOLDS]     = owner;
    own_status[dmc_pkg::BIT_REQUESTED]                        = req_flag[0];
    own_status[dmc_pkg::PORT_NIBBLE + dmc_pkg::BIT_REQUESTED] = req_flag[1];
    own_status[dmc_pkg::BIT_ALERT_EN]                         = sel_alert[0];
    own_status[dmc_pkg::PORT_NIBBLE + dmc_pkg::BIT_ALERT_EN]  = sel_alert[1];
    own_status[dmc_pkg::BIT_CMD_ERR]                          = err_flag[0];
    own_status[dmc_pkg::PORT_NIBBLE + dmc_pkg::BIT_CMD_ERR]   = err_flag[1];
  end

  // Per-port decode; nothing here looks at the other port's lines
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic write_now;
    logic is_owner;
    logic is_take;
    logic is_clr;

    always_comb begin
      write_now      = port_req[p].valid & ~port_req[p].rd;
      is_owner       = (owner == 1'(p));
      is_take        = write_now & (port_req[p].code == dmc_pkg::CMD_TAKE_OVER);
      is_clr         = write_now & (port_req[p].code == dmc_pkg::CMD_CLEAR_FAULTS);
      take_ok[p]     = is_take & port_req[p].pec_ok & ~is_owner;
      clr_cmd[p]     = is_clr;
      bad_cmd[p]     = (is_take & ~port_req[p].pec_ok) | (write_now & ~is_owner & ~is_take & ~is_clr);
      own_stat_rd[p] = port_req[p].valid & port_req[p].rd & (port_req[p].code == dmc_pkg::CMD_OWN_STATUS);
      // Reads pass from both ports; writes only from the owner
      fwd_cmd[p]     = port_req[p].valid & (port_req[p].rd ? ~own_stat_rd[p] : (is_owner & ~is_take & ~is_clr));
    end

    always_ff @(posedge clk_sys) begin
      if (reset) begin
        port_rsp[p].rd_valid  <= 1'b0;
        port_rsp[p].rd_data   <= 8'h00;
        port_rsp[p].exec      <= 1'b0;
        port_rsp[p].exec_rd   <= 1'b0;
        port_rsp[p].exec_code <= 8'h00;
      end else begin
        port_rsp[p].rd_valid  <= own_stat_rd[p];
        port_rsp[p].exec      <= fwd_cmd[p];
        port_rsp[p].exec_rd   <= port_req[p].rd;
        port_rsp[p].exec_code <= port_req[p].code;
        if (own_stat_rd[p]) begin
          port_rsp[p].rd_data <= own_status;
        end
      end
    end

    // Stretch is a handshake term, combinational on purpose
    assign port_rsp[p].stretch = core_busy & (port_req[p].valid | port_req[p].wr_open);

    // Command error is sticky; a new error wins over the clear
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        err_flag[p] <= 1'b0;
      end else if (bad_cmd[p]) begin
        err_flag[p] <= 1'b1;
      end else if (clr_cmd[p]) begin
        err_flag[p] <= 1'b0;
      end
    end

    // Selector alert: set on transfer, cleared by this port's own clear
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        sel_alert[p] <= 1'b0;
      end else if (xfer_go) begin
        sel_alert[p] <= 1'b1;
      end else if (clr_cmd[p]) begin
        sel_alert[p] <= 1'b0;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (reset) begin
        alert_oe_n[p] <= 1'b1;
      end else begin
        alert_oe_n[p] <= ~(fault_alert | sel_alert[p]);
      end
    end

    assign alert_out[p] = 1'b0;

    nonowner_block_a: assert property (write_now && !is_owner && !is_take && !is_clr
      |=> !port_rsp[p].exec && err_flag[p]) else $error("non-owner write was executed");
    status_read_a: assert property (own_stat_rd[p]
      |=> port_rsp[p].rd_valid && port_rsp[p].rd_data == $past(own_status)) else $error("status read wrong");
  end

  // Ownership transfer; a read on the owner's port does not hold it back
  assign xfer_go = (xfer_state == dmc_pkg::XF_WAIT) & ~port_req[owner].wr_open;

  always_comb begin
    next_xfer_state = xfer_state;
    case (xfer_state)
      dmc_pkg::XF_IDLE: begin
        if (req_flag[~owner]) begin
          next_xfer_state = dmc_pkg::XF_WAIT;
        end
      end
      dmc_pkg::XF_WAIT: begin
        if (xfer_go) begin
          next_xfer_state = dmc_pkg::XF_IDLE;
        end
      end
      default: begin
        next_xfer_state = dmc_pkg::XF_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      xfer_state <= dmc_pkg::XF_IDLE;
    end else begin
      xfer_state <= next_xfer_state;
    end
  end

  // A bias reset gives ownership to port 0; each transfer flips it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      owner <= dmc_pkg::OWN_STATUS_RESET[dmc_pkg::BIT_HOLDS] ? 1'b0 : 1'b1;
    end else if (xfer_go) begin
      owner <= ~owner;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      req_flag <= 2'b00;
    end else if (xfer_go) begin
      req_flag <= 2'b00;
    end else begin
      req_flag <= req_flag | take_ok;
    end
  end

  // Notification latch
  assign owner_clr   = clr_cmd[owner];
  assign stat_change = (status_live ^ stat_ref) & ~ext_mask;
  assign fault_alert = pwr_note | (|notif);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stat_ref <= dmc_pkg::STAT_ZERO;
    end else if (final_state) begin
      stat_ref <= status_live;
    end
  end

  // Changes seen in this cycle survive a clear arriving with them
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      notif <= dmc_pkg::STAT_ZERO;
    end else if (owner_clr) begin
      notif <= final_state ? stat_change : dmc_pkg::STAT_ZERO;
    end else if (final_state) begin
      notif <= notif | stat_change;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pwr_note <= 1'b1;
    end else if ((port_req[owner].valid & port_req[owner].rd &
                 (port_req[owner].code == dmc_pkg::CMD_STATUS_WORD)) | owner_clr) begin
      pwr_note <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fault_clear <= 1'b0;
      alarm       <= 1'b0;
    end else begin
      fault_clear <= owner_clr;
      alarm       <= |notif;
    end
  end

  logic past_wr_open;
  always_ff @(posedge clk_sys) begin
    past_wr_open <= port_req[owner].wr_open;
  end

  hold_onehot_a: assert property (own_status[dmc_pkg::BIT_HOLDS] != own_status[dmc_pkg::PORT_NIBBLE])
    else $error("holds-control flags not exclusive");
  owner_cause_a: assert property (owner != $past(owner) |-> $past(req_flag[~owner]))
    else $error("owner moved without a valid request");
  xfer_stop_a: assert property (owner != $past(owner) |-> !past_wr_open)
    else $error("transfer during open control transaction");
  alert_xfer_a: assert property (owner != $past(owner) |-> sel_alert == 2'b11 ##1 alert_oe_n == 2'b00)
    else $error("alerts missing after transfer");
  clear_owner_a: assert property ($rose(fault_clear) |-> $past(clr_cmd[owner]))
    else $error("fault clear from non-owner");
  notif_keep_a: assert property ((|($past(notif) & ~notif)) |-> $past(owner_clr))
    else $error("latched notification lost");
  ext_quiet_a: assert property (!owner_clr && ((status_live ^ stat_ref) & ~ext_mask) == '0
    |=> notif == $past(notif)) else $error("external fault latched");
  pec_gate_a: assert property (port_req[0].valid && !port_req[0].rd && !port_req[0].pec_ok
    && port_req[0].code == dmc_pkg::CMD_TAKE_OVER && !req_flag[0] |=> !req_flag[0])
    else $error("take-over acted on bad PEC");

endmodule

// >>> bench/dmc_host_model.sv
`timescale 1ns/1ps

module dmc_host_model (
  // System
  input  wire logic                clk_sys,
  // Both host ports, index is port number
  output dmc_pkg::dmc_req_t [1:0]  req
);
  initial req = '0;

  // One whole command per pulse, never left half sent
  task automatic xfer(input logic [1:0] ports, input logic rd, input logic [7:0] code, input logic pec);
    @(posedge clk_sys);
    #1;
    for (int p = 0; p < 2; p++) begin
      if (ports[p]) begin
        req[p].valid  = 1'b1;
        req[p].rd     = rd;
        req[p].code   = code;
        req[p].pec_ok = pec;
      end
    end
    @(posedge clk_sys);
    #1;
    // The code goes stale once the pulse ends, so show junk, not the last value
    for (int p = 0; p < 2; p++) begin
      req[p].valid = 1'b0;
      req[p].code  = ~req[p].code;
    end
  endtask

  // Control transaction open until its STOP
  task automatic hold_open(input int p, input logic open);
    @(posedge clk_sys);
    #1;
    req[p].wr_open = open;
  endtask
endmodule

// >>> bench/dmc_arbiter_tb.sv
`timescale 1ns/1ps

module dmc_arbiter_tb;
  logic                        clk_sys     = 1'b0;
  logic                        reset       = 1'b1;
  dmc_pkg::dmc_req_t [1:0]     port_req;
  dmc_pkg::dmc_rsp_t [1:0]     port_rsp;
  logic [1:0]                  alert_out;
  logic [1:0]                  alert_oe_n;
  logic                        core_busy   = 1'b0;
  logic [dmc_pkg::STAT_W-1:0]  status_live = dmc_pkg::STAT_ZERO;
  logic [dmc_pkg::STAT_W-1:0]  ext_mask    = 16'h0002;
  logic                        final_state = 1'b0;
  logic                        fault_clear;
  logic                        alarm;
  logic [dmc_pkg::STAT_W-1:0]  notif;
  logic                        owner;
  int                          failures    = 0;
  int                          cmp_count   = 0;

  always #5 clk_sys = ~clk_sys;

  dmc_host_model u_host (.clk_sys(clk_sys), .req(port_req));

  dmc_arbiter u_dut (.clk_sys(clk_sys), .reset(reset), .port_req(port_req), .port_rsp(port_rsp),
    .alert_out(alert_out), .alert_oe_n(alert_oe_n), .core_busy(core_busy), .status_live(status_live),
    .ext_mask(ext_mask), .final_state(final_state), .fault_clear(fault_clear), .alarm(alarm),
    .notif(notif), .owner(owner));

  task automatic chk(input logic [16:0] seen, input logic [16:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic read_both(input logic [7:0] exp);
    u_host.xfer(2'b11, 1'b1, dmc_pkg::CMD_OWN_STATUS, 1'b1);
    chk(port_rsp[0].rd_valid & port_rsp[1].rd_valid, 1'b1, "dual read strobe");
    chk(port_rsp[0].rd_data, exp, "status byte on port 0");
    chk(port_rsp[1].rd_data, exp, "status byte on port 1");
  endtask

  task automatic t_powerup();
    cyc(1);
    chk(alert_oe_n, 2'b00, "power-up alert");
    read_both(dmc_pkg::OWN_STATUS_RESET);
    u_host.xfer(2'b01, 1'b1, dmc_pkg::CMD_STATUS_WORD, 1'b1);
    cyc(1);
    chk(alert_oe_n, 2'b11, "power-up notice cleared");
  endtask

  task automatic t_refuse();
    u_host.xfer(2'b01, 1'b0, dmc_pkg::CMD_STATUS_WORD, 1'b1);
    chk(port_rsp[0].exec, 1'b1, "owner write forwarded");
    chk({port_rsp[0].exec_rd, port_rsp[0].exec_code}, {1'b0, dmc_pkg::CMD_STATUS_WORD}, "forwarded code");
    u_host.xfer(2'b10, 1'b0, dmc_pkg::CMD_STATUS_WORD, 1'b1);
    chk(port_rsp[1].exec, 1'b0, "non-owner write forwarded");
    read_both(8'h81);
    u_host.xfer(2'b10, 1'b0, dmc_pkg::CMD_CLEAR_FAULTS, 1'b1);
    chk(fault_clear, 1'b0, "non-owner cleared faults");
    u_host.xfer(2'b10, 1'b0, dmc_pkg::CMD_TAKE_OVER, 1'b0);
    cyc(4);
    chk(owner, 1'b0, "take-over with bad check byte");
    read_both(8'h81);
    u_host.xfer(2'b10, 1'b0, dmc_pkg::CMD_CLEAR_FAULTS, 1'b1);
  endtask

  task automatic t_takeover();
    u_host.hold_open(0, 1'b1);
    core_busy = 1'b1;
    cyc(1);
    chk(port_rsp[0].stretch, 1'b1, "stretch while busy");
    core_busy = 1'b0;
    u_host.xfer(2'b10, 1'b0, dmc_pkg::CMD_TAKE_OVER, 1'b1);
    cyc(5);
    chk(owner, 1'b0, "transfer before stop");
    read_both(8'h21);
    u_host.hold_open(0, 1'b0);
    cyc(3);
    chk(owner, 1'b1, "owner after take-over");
    chk(alert_oe_n, 2'b00, "both alerts after transfer");
    read_both(8'h54);
    u_host.xfer(2'b01, 1'b0, dmc_pkg::CMD_CLEAR_FAULTS, 1'b1);
    cyc(1);
    chk(alert_oe_n, 2'b01, "port 0 alert cleared alone");
    u_host.xfer(2'b10, 1'b0, dmc_pkg::CMD_CLEAR_FAULTS, 1'b1);
    chk(fault_clear, 1'b1, "owner clear pulse");
    cyc(1);
    chk(alert_oe_n, 2'b11, "port 1 alert cleared");
  endtask

  task automatic t_faults();
    status_live = 16'h0003;
    cyc(2);
    chk(notif, 16'h0000, "latched before final state");
    final_state = 1'b1;
    cyc(2);
    chk(notif, 16'h0001, "external bit kept out");
    chk({alarm, alert_oe_n}, 3'b100, "alarm on both lines");
    status_live = 16'h0007;
    cyc(2);
    chk(notif, 16'h0005, "later change added");
    u_host.xfer(2'b01, 1'b0, dmc_pkg::CMD_CLEAR_FAULTS, 1'b1);
    chk(notif, 16'h0005, "non-owner clear ignored");
    u_host.xfer(2'b10, 1'b0, dmc_pkg::CMD_CLEAR_FAULTS, 1'b1);
    cyc(1);
    chk({alarm, notif}, 17'h00000, "owner clear");
  endtask

  // Port 0 takes control back while the owner is only reading
  task automatic t_giveback();
    u_host.xfer(2'b01, 1'b0, dmc_pkg::CMD_TAKE_OVER, 1'b0);
    cyc(3);
    chk(owner, 1'b1, "port 0 take-over with bad check byte");
    u_host.xfer(2'b01, 1'b0, dmc_pkg::CMD_TAKE_OVER, 1'b1);
    u_host.xfer(2'b10, 1'b1, dmc_pkg::CMD_STATUS_WORD, 1'b1);
    chk(owner, 1'b0, "transfer during owner read");
    chk({port_rsp[1].exec, port_rsp[1].exec_rd, port_rsp[1].exec_code},
        {2'b11, dmc_pkg::CMD_STATUS_WORD}, "owner read forwarded");
    read_both(8'h4D);
    u_host.xfer(2'b11, 1'b0, dmc_pkg::CMD_CLEAR_FAULTS, 1'b1);
    chk(fault_clear, 1'b1, "clear from both ports");
    cyc(1);
    chk(alert_oe_n, 2'b11, "both alerts cleared");
    chk(alert_out, 2'b00, "alert pin drive level");
    read_both(dmc_pkg::OWN_STATUS_RESET);
  endtask

  initial begin
    cyc(5);
    reset = 1'b0;
    t_powerup();
    t_refuse();
    t_takeover();
    t_faults();
    t_giveback();
    summarize();
  end

  // Whole run needs some 80 cycles
  initial begin
    #20000;
    failures++;
    summarize();
  end
endmodule
